// ==== design/sfs_pkg.sv ====
/*
 * Shared constants for the serial flash link framing block: page sizes,
 * buffer depth, reset values and the self-timed program/erase duration.
 * Assumes a single core clock of 20 MHz.
 */
package sfs_pkg;

    // ----------------------------------------------------------------
    // Clock and timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    // Plain default; the real duration is a process figure
    localparam int PROG_TIME_US = 4000;
    localparam int PROG_CYCLES = (PROG_TIME_US * 1000) / CLK_PERIOD_NS;

    // ----------------------------------------------------------------
    // Page and buffer geometry
    // ----------------------------------------------------------------
    localparam logic [9:0] PAGE_BYTES_528 = 10'h210;
    localparam logic [9:0] PAGE_BYTES_512 = 10'h200;
    localparam int BUF_DEPTH = 528;
    localparam int ADDR_W = 10;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic PAGE_512_RST = 1'b0;
    localparam logic [2:0] PIN_SYNC_RST = 3'h6;
    localparam logic [2:0] BIT_CNT_RST = 3'h0;
    localparam logic [9:0] BYTE_CNT_RST = 10'h000;
    localparam logic [9:0] BYTE_CNT_MAX = 10'h3ff;
    localparam logic [9:0] ADDR_RST = 10'h000;
    localparam logic [31:0] TIMER_RST = 32'h0000_0000;

    // Last valid byte address of a page for the active size
    function automatic logic [9:0] page_last(input logic sel_512);
        page_last = sel_512 ? PAGE_BYTES_512 - 10'h001 : PAGE_BYTES_528 - 10'h001;
    endfunction : page_last

    // Next buffer address, wrapping at the page end
    function automatic logic [9:0] next_addr(input logic [9:0] a, input logic sel_512);
        next_addr = (a == page_last(sel_512)) ? ADDR_RST : a + 10'h001;
    endfunction : next_addr

endpackage : sfs_pkg

// ==== design/sfs_sync.sv ====
/*
 * Two-flop synchroniser for a group of independent level inputs.
 * Assumes each bit is asynchronous to core_clk and only levels matter.
 */
`timescale 1ns/1ps
module sfs_sync #(
    parameter int W = 3,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Levels
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta;

    // First stage feeds only the second stage
    always_ff @(posedge core_clk) begin
        if (rst) begin
            meta <= RST_VAL;
            sync_out <= RST_VAL;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end

endmodule : sfs_sync

// ==== design/sfs_buffers.sv ====
/*
 * Two independent page buffers with one write and one registered read port.
 * Assumes the caller keeps addresses below the active page size.
 */
`timescale 1ns/1ps
module sfs_buffers (
    // Clock
    input wire logic core_clk,
    // Write port
    input wire logic wr_en,
    input wire logic wr_sel,
    input wire logic [sfs_pkg::ADDR_W-1:0] wr_addr,
    input wire logic [7:0] wr_data,
    // Read port
    input wire logic rd_sel,
    input wire logic [sfs_pkg::ADDR_W-1:0] rd_addr,
    output logic [7:0] rd_data
);
    import sfs_pkg::*;

    logic [7:0] buf0 [BUF_DEPTH];
    logic [7:0] buf1 [BUF_DEPTH];

    // Separate arrays so either can be filled while the other is read
    always_ff @(posedge core_clk) begin
        if (wr_en && !wr_sel) begin
            buf0[wr_addr] <= wr_data;
        end
        if (wr_en && wr_sel) begin
            buf1[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge core_clk) begin
        rd_data <= rd_sel ? buf1[rd_addr] : buf0[rd_addr];
    end

endmodule : sfs_buffers

// ==== design/sfs_framing.sv ====
/*
 * Serial flash link framing: select/deselect framing, bit sampling and
 * output shifting on the host clock edges, standby and self-timed busy,
 * page size selection and the two page buffers.
 * Assumes the host drives select, clock and data in mode 0 or 3 at a clock
 * slow enough (well under a quarter of core_clk) for oversampling.
 */
`timescale 1ns/1ps
module sfs_framing #(
    parameter int PROG_CYCLES = sfs_pkg::PROG_CYCLES
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Host link
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    output logic so_out,
    output logic so_oe,
    // Frame events
    output logic frame_start,
    output logic frame_end,
    // Received bytes
    output logic [7:0] rx_data,
    output logic rx_valid,
    output logic [9:0] byte_index,
    // Transmit source
    input wire logic [7:0] tx_data,
    input wire logic tx_from_buf,
    // Self-timed cycle
    input wire logic prog_arm,
    output logic busy,
    output logic standby,
    // Page size
    input wire logic page_512_set,
    input wire logic page_528_set,
    output logic [9:0] page_bytes,
    // Buffer access
    input wire logic buf_wr,
    input wire logic buf_rd,
    input wire logic buf_sel
);
    import sfs_pkg::*;

    // ----------------------------------------------------------------
    // Pin synchronisation and edge detection
    // ----------------------------------------------------------------
    logic [2:0] pins_s;
    logic cs_s;
    logic sck_s;
    logic si_s;
    logic cs_d;
    logic sck_d;
    logic sel;
    logic sck_rise;
    logic sck_fall;

    sfs_sync #(
        .W(3),
        .RST_VAL(PIN_SYNC_RST)
    ) u_sync (
        .core_clk(core_clk),
        .rst(rst),
        .async_in({cs_n, sck, si}),
        .sync_out(pins_s)
    );

    assign cs_s = pins_s[2];
    assign sck_s = pins_s[1];
    assign si_s = pins_s[0];

    // Delayed copies track the clock even while deselected, so a mode 3
    // frame does not see a false edge from a stale idle level
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cs_d <= PIN_SYNC_RST[2];
            sck_d <= PIN_SYNC_RST[1];
        end else begin
            cs_d <= cs_s;
            sck_d <= sck_s;
        end
    end

    assign sel = !cs_s;
    assign frame_start = cs_d && !cs_s;
    assign frame_end = !cs_d && cs_s;
    assign sck_rise = sel && sck_s && !sck_d;
    assign sck_fall = sel && !sck_s && sck_d;

    // ----------------------------------------------------------------
    // Receive shifter and counters
    // ----------------------------------------------------------------
    logic [2:0] bit_cnt;
    logic [6:0] rx_sh;

    always_ff @(posedge core_clk) begin
        if (rst || frame_start) begin
            bit_cnt <= BIT_CNT_RST;
            byte_index <= BYTE_CNT_RST;
        end else if (sck_rise) begin
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == 3'h7 && byte_index != BYTE_CNT_MAX) begin
                byte_index <= byte_index + 10'h001;
            end
        end
    end

    // Sampling only happens on a selected rising edge
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rx_sh <= 7'h00;
            rx_data <= 8'h00;
            rx_valid <= 1'b0;
        end else begin
            rx_valid <= 1'b0;
            if (sck_rise) begin
                rx_sh <= {rx_sh[5:0], si_s};
                if (bit_cnt == 3'h7) begin
                    rx_data <= {rx_sh, si_s};
                    rx_valid <= 1'b1;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Page size and buffers
    // ----------------------------------------------------------------
    logic page_512;
    logic [9:0] buf_addr;
    logic [7:0] buf_rd_data;
    logic buf_wr_now;
    logic tx_load;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            page_512 <= PAGE_512_RST;
        end else if (page_512_set) begin
            page_512 <= 1'b1;
        end else if (page_528_set) begin
            page_512 <= 1'b0;
        end
    end

    assign page_bytes = page_512 ? PAGE_BYTES_512 : PAGE_BYTES_528;

    // Buffer writes are independent of busy: a buffer fills during a program
    assign buf_wr_now = rx_valid && buf_wr && sel;
    assign tx_load = sck_fall && bit_cnt == BIT_CNT_RST;

    always_ff @(posedge core_clk) begin
        if (rst || frame_start) begin
            buf_addr <= ADDR_RST;
        end else if (buf_wr_now || (tx_load && buf_rd && tx_from_buf)) begin
            buf_addr <= next_addr(buf_addr, page_512);
        end
    end

    sfs_buffers u_buffers (
        .core_clk(core_clk),
        .wr_en(buf_wr_now),
        .wr_sel(buf_sel),
        .wr_addr(buf_addr),
        .wr_data(rx_data),
        .rd_sel(buf_sel),
        .rd_addr(buf_addr),
        .rd_data(buf_rd_data)
    );

    // ----------------------------------------------------------------
    // Transmit shifter
    // ----------------------------------------------------------------
    logic [6:0] tx_sh;

    // A new byte is taken on the falling edge that opens each byte slot
    // In mode 0 no falling edge precedes the first bit, so a frame's first slot carries no data
    always_ff @(posedge core_clk) begin
        if (rst) begin
            tx_sh <= 7'h00;
            so_out <= 1'b0;
        end else if (tx_load) begin
            tx_sh <= tx_from_buf ? buf_rd_data[6:0] : tx_data[6:0];
            so_out <= tx_from_buf ? buf_rd_data[7] : tx_data[7];
        end else if (sck_fall) begin
            tx_sh <= {tx_sh[5:0], 1'b0};
            so_out <= tx_sh[6];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            so_oe <= 1'b0;
        end else begin
            so_oe <= sel && !frame_end;
        end
    end

    // ----------------------------------------------------------------
    // Self-timed program/erase and standby
    // ----------------------------------------------------------------
    logic prog_armed;
    logic [31:0] prog_timer;

    // An arm in the opening cycle of a frame outlives the clear of the old one
    always_ff @(posedge core_clk) begin
        if (rst) begin
            prog_armed <= 1'b0;
        end else if (prog_arm && sel && !busy) begin
            prog_armed <= 1'b1;
        end else if (frame_start) begin
            prog_armed <= 1'b0;
        end
    end

    // Cycle is launched only once the frame closes
    // No abort path: a later frame cannot cut a running cycle short
    always_ff @(posedge core_clk) begin
        if (rst) begin
            busy <= 1'b0;
            prog_timer <= TIMER_RST;
        end else if (frame_end && prog_armed && !busy) begin
            busy <= 1'b1;
            prog_timer <= 32'(PROG_CYCLES - 1);
        end else if (busy) begin
            if (prog_timer == TIMER_RST) begin
                busy <= 1'b0;
            end else begin
                prog_timer <= prog_timer - 32'h0000_0001;
            end
        end
    end

    // Only ordinary standby exists here; deep power-down needs a command
    assign standby = cs_s && !busy;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    // Checks run on the synced pins, two core cycles behind the host
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    standby_entry_a: assert property (frame_end && !prog_armed && !busy |=> standby)
        else $error("deselected idle device not in standby");
    so_hiz_a: assert property (cs_s && $past(cs_s) |-> !so_oe)
        else $error("serial output driven while deselected");
    rx_ignore_a: assert property (rx_valid |-> !$past(cs_s))
        else $error("byte accepted while deselected");
    frame_open_a: assert property ($fell(cs_s) |-> frame_start)
        else $error("falling select did not open a frame");
    frame_close_a: assert property ($rose(cs_s) |-> frame_end ##1 !frame_end)
        else $error("rising select did not close a frame once");
    busy_hold_a: assert property (frame_end && prog_armed && !busy |=> (busy && !standby) [*8])
        else $error("standby entered before self-timed cycle ended");
    sample_edge_a: assert property (rx_valid |-> $past(sck_rise) && $past(bit_cnt) == 3'h7)
        else $error("byte completed without a rising edge");
    shift_edge_a: assert property (sel && $past(sel) && so_out != $past(so_out) |-> $past(sck_fall))
        else $error("output bit changed off a falling edge");
    page_default_a: assert property ($past(rst) |-> page_bytes == PAGE_BYTES_528)
        else $error("page size not 528 after reset");
    busy_end_a: assert property ($fell(busy) |-> $past(prog_timer) == TIMER_RST)
        else $error("busy ended before timer expired");
    count_clear_a: assert property (frame_start |=> bit_cnt == BIT_CNT_RST && byte_index == BYTE_CNT_RST)
        else $error("counters not cleared at frame start");
    rx_pulse_a: assert property (rx_valid |=> !rx_valid)
        else $error("byte strobe held longer than one cycle");
    byte_step_a: assert property (rx_valid |->
        byte_index == $past(byte_index) + 10'h001 || byte_index == BYTE_CNT_MAX)
        else $error("byte count did not step with a received byte");
    idle_count_a: assert property (!sel |=> $stable(bit_cnt) && $stable(byte_index))
        else $error("counters moved while deselected");
    so_quiet_a: assert property (!sel |=> $stable(so_out))
        else $error("output bit moved while deselected");
    oe_select_a: assert property (sel && !frame_start |-> so_oe)
        else $error("output not driven inside a frame");
    prog_len_a: assert property ($rose(busy) |-> prog_timer == 32'(PROG_CYCLES - 1))
        else $error("self-timed cycle started with wrong length");
    page_512_a: assert property (page_512_set |=> page_bytes == PAGE_BYTES_512)
        else $error("page size not 512 after select");
    page_528_a: assert property (page_528_set && !page_512_set |=> page_bytes == PAGE_BYTES_528)
        else $error("page size not 528 after select");

    mode3_frame_c: cover property (frame_start && sck_s);
    mode0_frame_c: cover property (frame_start && !sck_s);
    buf_during_prog_c: cover property (busy && buf_wr_now);
    prog_launch_c: cover property (frame_end && prog_armed);
    partial_frame_c: cover property (frame_end && bit_cnt != BIT_CNT_RST);

endmodule : sfs_framing

// ==== tb/sfs_host_model.sv ====
/*
 * Host link master model: drives select, serial clock and serial data in
 * mode 0 or 3 and samples the serial output.
 * Assumes the bench core clock; every change lands on its falling edge.
 */
`timescale 1ns/1ps
module sfs_host_model (
    // Clock
    input wire logic core_clk,
    // Link
    output logic cs_n,
    output logic sck,
    output logic si,
    input wire logic so_out
);
    logic idle_hi = 1'b0;

    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
    end

    // ----------------------------------------------------------------
    // Link timing
    // ----------------------------------------------------------------
    // Four core cycles a half gives the 400 ns link clock
    task automatic half();
        repeat (4) @(negedge core_clk);
    endtask : half

    task automatic start(input logic mode3);
        idle_hi = mode3;
        sck = mode3;
        half();
        cs_n = 1'b0;
        half();
        half();
    endtask : start

    task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
        for (int i = 7; i > 7 - nbits; i--) begin
            sck = 1'b0;
            si = tx[i];
            half();
            rx[i] = so_out;
            sck = 1'b1;
            half();
        end
    endtask : xfer

    task automatic stop();
        sck = idle_hi;
        half();
        cs_n = 1'b1;
        // Released line shows a changed level, not the last bit
        si = ~si;
        half();
    endtask : stop

    // Activity while deselected, only when a scenario asks for it
    task automatic noise();
        for (int i = 0; i < 16; i++) begin
            sck = ~sck;
            si = ~si;
            half();
        end
    endtask : noise
endmodule : sfs_host_model

// ==== tb/testbench.sv ====
/*
 * Self-checking bench for the link framing block, driven by the host model.
 * Assumes a 20 MHz core clock and a shortened self-timed cycle.
 */
`timescale 1ns/1ps
module testbench;
    import sfs_pkg::*;
    localparam int PROG = 200;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic cs_n, sck, si, so_out, so_oe, frame_start, frame_end, rx_valid, busy, standby;
    logic [7:0] rx_data;
    logic [9:0] byte_index, page_bytes;
    logic [7:0] tx_data = 8'h5a;
    logic tx_from_buf = 1'b0, prog_arm = 1'b0, page_512_set = 1'b0, page_528_set = 1'b0;
    logic buf_wr = 1'b0, buf_rd = 1'b0, buf_sel = 1'b0;
    int miscompares = 0, samples_checked = 0, cycles = 0, starts = 0, ends = 0, busy_len = 0;
    logic [7:0] rxq[$];
    logic [15:0] got;
    logic so_line;

    // ----------------------------------------------------------------
    // Instances and clock
    // ----------------------------------------------------------------
    sfs_framing #(.PROG_CYCLES(PROG)) u_dut (.core_clk(core_clk), .rst(rst), .cs_n(cs_n),
        .sck(sck), .si(si), .so_out(so_out), .so_oe(so_oe), .frame_start(frame_start),
        .frame_end(frame_end), .rx_data(rx_data), .rx_valid(rx_valid), .byte_index(byte_index),
        .tx_data(tx_data), .tx_from_buf(tx_from_buf), .prog_arm(prog_arm), .busy(busy),
        .standby(standby), .page_512_set(page_512_set), .page_528_set(page_528_set),
        .page_bytes(page_bytes), .buf_wr(buf_wr), .buf_rd(buf_rd), .buf_sel(buf_sel));
    // A released output shows the inverse of its last bit, so a sample outside the drive fails
    assign so_line = so_oe ? so_out : ~so_out;
    sfs_host_model u_host (.core_clk(core_clk), .cs_n(cs_n), .sck(sck), .si(si), .so_out(so_line));

    always #25 core_clk = ~core_clk;

    // ----------------------------------------------------------------
    // Monitors and reporting
    // ----------------------------------------------------------------
    always @(posedge core_clk) begin
        cycles++;
        if (rx_valid === 1'b1) rxq.push_back(rx_data);
        if (frame_start === 1'b1) starts++;
        if (frame_end === 1'b1) ends++;
        if (busy === 1'b1) busy_len++;
        if (cycles == 10000) begin
            miscompares++;
            give_verdict();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic give_verdict();
        $display("Compared %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : give_verdict

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic frame(input logic mode3, input logic [15:0] tx, output logic [15:0] rx);
        int s0;
        int e0;
        s0 = starts;
        e0 = ends;
        rxq.delete();
        u_host.start(mode3);
        check(so_oe, 1'b1);
        check(standby, 1'b0);
        u_host.xfer(tx[15:8], 8, rx[15:8]);
        u_host.xfer(tx[7:0], 8, rx[7:0]);
        u_host.stop();
        check(starts - s0, 1);
        check(ends - e0, 1);
        check(rxq.size(), 2);
        check({rxq[0], rxq[1]}, tx);
        check(byte_index, 10'h002);
    endtask : frame

    task automatic t_page();
        check(page_bytes, PAGE_BYTES_528);
        page_512_set = 1'b1;
        @(negedge core_clk);
        page_512_set = 1'b0;
        @(negedge core_clk);
        check(page_bytes, PAGE_BYTES_512);
        page_528_set = 1'b1;
        @(negedge core_clk);
        page_528_set = 1'b0;
        @(negedge core_clk);
        check(page_bytes, PAGE_BYTES_528);
        // A reset in mid-run must bring back the default page size
        page_512_set = 1'b1;
        @(negedge core_clk);
        page_512_set = 1'b0;
        @(negedge core_clk);
        check(page_bytes, PAGE_BYTES_512);
        rst = 1'b1;
        repeat (3) @(negedge core_clk);
        rst = 1'b0;
        repeat (3) @(negedge core_clk);
        check(page_bytes, PAGE_BYTES_528);
        check(so_oe, 1'b0);
        check(standby, 1'b1);
    endtask : t_page

    task automatic t_modes();
        for (int m = 0; m < 2; m++) begin
            frame(m[0], 16'ha53c, got);
            check(got[7:0], tx_data);
            if (m == 1) check(got[15:8], tx_data);
            check(starts, ends);
            check(standby, 1'b1);
            check(so_oe, 1'b0);
        end
    endtask : t_modes

    task automatic t_idle();
        int s0;
        s0 = starts;
        rxq.delete();
        u_host.noise();
        check(rxq.size(), 0);
        check(starts, s0);
        check(byte_index, 10'h002);
        check(so_oe, 1'b0);
    endtask : t_idle

    task automatic t_partial();
        rxq.delete();
        u_host.start(1'b0);
        u_host.xfer(8'hf0, 4, got[7:0]);
        u_host.stop();
        check(rxq.size(), 0);
        frame(1'b0, 16'h3c96, got);
    endtask : t_partial

    task automatic t_prog();
        u_host.start(1'b0);
        prog_arm = 1'b1;
        @(negedge core_clk);
        prog_arm = 1'b0;
        busy_len = 0;
        u_host.xfer(8'h11, 8, got[7:0]);
        u_host.stop();
        check(busy, 1'b1);
        // Buffer 1 is filled while the self-timed cycle runs
        buf_wr = 1'b1;
        buf_sel = 1'b1;
        frame(1'b0, 16'h817e, got);
        check(busy, 1'b1);
        check(standby, 1'b0);
        buf_sel = 1'b0;
        frame(1'b0, 16'hc318, got);
        buf_wr = 1'b0;
        for (int k = 0; k < 300 && busy !== 1'b0; k++) @(negedge core_clk);
        check(busy_len == PROG || busy_len == PROG + 1, 1'b1);
        @(negedge core_clk);
        check(standby, 1'b1);
        tx_from_buf = 1'b1;
        buf_rd = 1'b1;
        buf_sel = 1'b1;
        frame(1'b1, 16'h0000, got);
        check(got, 16'h817e);
        buf_sel = 1'b0;
        frame(1'b1, 16'h0000, got);
        check(got, 16'hc318);
        tx_from_buf = 1'b0;
        buf_rd = 1'b0;
    endtask : t_prog

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (20) @(negedge core_clk);
        rst = 1'b0;
        repeat (5) @(negedge core_clk);
        check(so_oe, 1'b0);
        check(busy, 1'b0);
        check(standby, 1'b1);
        t_page();
        t_modes();
        t_idle();
        t_partial();
        t_prog();
        give_verdict();
    end
endmodule : testbench
